// [hw/split_pulse_pkg.sv]
package split_pulse_pkg;
  localparam int          NUM_SETS      = 4;
  localparam int          CNT_W         = 16;
  localparam logic [15:0] WIDTH_RST_0   = 16'h0005;
  localparam logic [15:0] WIDTH_RST_1   = 16'h000a;
  localparam logic [15:0] WIDTH_RST_2   = 16'h01f4;
  localparam logic [15:0] WIDTH_RST_3   = 16'h1388;
  localparam logic [15:0] PERIOD_RST_0  = 16'h000a;
  localparam logic [15:0] PERIOD_RST_1  = 16'h0014;
  localparam logic [15:0] PERIOD_RST_2  = 16'h03e8;
  localparam logic [15:0] PERIOD_RST_3  = 16'h2710;
  localparam logic [15:0] COUNT_RST_0   = 16'h0000;
  localparam logic [15:0] COUNT_RST_1   = 16'h0000;
  localparam logic [15:0] COUNT_RST_2   = 16'h000a;
  localparam logic [15:0] COUNT_RST_3   = 16'h000a;
  // avalon word offsets (byte addresses)
  localparam logic [7:0]  OFS_CTRL      = 8'h00;
  localparam logic [7:0]  OFS_STATUS    = 8'h04;
  localparam logic [7:0]  OFS_SET_BASE  = 8'h10;
  localparam int          SET_STRIDE_SH = 4;
  localparam logic [7:0]  OFS_PERIOD    = 8'h00;
  localparam logic [7:0]  OFS_WIDTH     = 8'h04;
  localparam logic [7:0]  OFS_COUNT     = 8'h08;
  localparam int          CTRL_START_B  = 0;
  localparam int          CTRL_STOP_B   = 1;
  localparam int          CTRL_SEL_LSB  = 4;

  typedef struct packed {
    logic [15:0] period;
    logic [15:0] width;
    logic [15:0] count;
  } pulse_set_t;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_RUN  = 1'b1
  } run_state_t;
endpackage

// [hw/split_pulse_generator.sv]
// Operation
// - four independent period/width/count sets are held and the set is picked at start.
// - the period runs from one pulse start to the next, counted in drive pulses, 2 to 65535.
// - each output pulse stays high for a width of 1 to 65534 drive pulses, then goes low.
// - a count of 1 to 65535 yields exactly that many pulses and then the run ends itself.
// - a count of zero runs until a manual stop, the stop command or motion ceasing.
// - raw drive pulses are counted, with no position scaling applied.
// - widths reset to 5, 10, 500 and 5000.
// - periods reset to 10, 20, 1000 and 10000.
module split_pulse_generator (
  input  wire logic                 mclk_i,
  input  wire logic                 reset_i,
  input  wire logic [7:0]           avs_address_i,
  input  wire logic                 avs_read_i,
  input  wire logic                 avs_write_i,
  input  wire logic [31:0]          avs_writedata_i,
  output logic      [31:0]          avs_readdata_o,
  output logic                      avs_waitrequest_o,
  input  wire logic                 drive_pulse_i,
  input  wire logic                 axis_moving_i,
  input  wire logic                 pulse_train_start_cmd_i,
  input  wire logic                 pulse_train_stop_cmd_i,
  input  wire logic [1:0]           start_set_sel_i,
  output logic                      split_pulse_o,
  output logic                      busy_o
);
  import split_pulse_pkg::*;

  pulse_set_t       set_reg [NUM_SETS];
  pulse_set_t       act_reg;
  run_state_t       state_reg;
  logic [2:0]       dp_sync_reg;
  logic [2:0]       mv_sync_reg;
  logic             dp_level_reg;
  logic             mv_level_reg;
  logic [15:0]      phase_reg;
  logic [15:0]      done_reg;
  logic             out_reg;
  logic             ack_reg;
  logic [31:0]      rdata_reg;
  logic             sw_start;
  logic             sw_stop;
  logic [1:0]       sw_sel;
  logic             dp_edge;
  logic             any_stop;
  logic             do_start;
  logic [1:0]       start_sel;
  logic             last_pulse;
  logic             start_ok;
  logic             run_stop;
  logic             run_edge;
  logic             begin_pulse;
  logic             finish_run;
  logic             wrap_phase;
  logic             width_hit;

  function automatic logic set_hit(input logic [7:0] a, input int s, input logic [7:0] f);
    set_hit = (a == 8'(OFS_SET_BASE + 8'(s << SET_STRIDE_SH) + f));
  endfunction

  // avalon slave: one wait cycle, then ack
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_reg;
  assign avs_readdata_o    = rdata_reg;
  wire bus_wr = avs_write_i & ack_reg;
  wire bus_rd = avs_read_i & ~ack_reg;

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= (avs_read_i | avs_write_i) & ~ack_reg;
    end
  end

  assign sw_start = bus_wr && avs_address_i == OFS_CTRL && avs_writedata_i[CTRL_START_B];
  assign sw_stop  = bus_wr && avs_address_i == OFS_CTRL && avs_writedata_i[CTRL_STOP_B];
  assign sw_sel   = avs_writedata_i[CTRL_SEL_LSB +: 2];

  // parameter sets with reset defaults
  localparam pulse_set_t SET_RST [NUM_SETS] = '{
    '{PERIOD_RST_0, WIDTH_RST_0, COUNT_RST_0},
    '{PERIOD_RST_1, WIDTH_RST_1, COUNT_RST_1},
    '{PERIOD_RST_2, WIDTH_RST_2, COUNT_RST_2},
    '{PERIOD_RST_3, WIDTH_RST_3, COUNT_RST_3}};

  generate
    for (genvar s = 0; s < NUM_SETS; s++) begin : g_set
      always_ff @(posedge mclk_i) begin
        if (reset_i) begin
          set_reg[s] <= SET_RST[s];
        end else if (bus_wr) begin
          if (set_hit(avs_address_i, s, OFS_PERIOD)) begin
            set_reg[s].period <= avs_writedata_i[15:0];
          end
          if (set_hit(avs_address_i, s, OFS_WIDTH)) begin
            set_reg[s].width <= avs_writedata_i[15:0];
          end
          if (set_hit(avs_address_i, s, OFS_COUNT)) begin
            set_reg[s].count <= avs_writedata_i[15:0];
          end
        end
      end
    end
  endgenerate

  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      rdata_reg <= 32'h0000_0000;
    end else if (bus_rd) begin
      rdata_reg <= 32'h0000_0000;
      if (avs_address_i == OFS_STATUS) begin
        rdata_reg <= {done_reg, 14'h0000, out_reg, state_reg == ST_RUN};
      end
      for (int s = 0; s < NUM_SETS; s++) begin
        if (set_hit(avs_address_i, s, OFS_PERIOD)) begin
          rdata_reg <= {16'h0000, set_reg[s].period};
        end
        if (set_hit(avs_address_i, s, OFS_WIDTH)) begin
          rdata_reg <= {16'h0000, set_reg[s].width};
        end
        if (set_hit(avs_address_i, s, OFS_COUNT)) begin
          rdata_reg <= {16'h0000, set_reg[s].count};
        end
      end
    end
  end

  // drive pulse pin: three stages, a change counts once stages 2 and 3 agree
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      dp_sync_reg  <= 3'h0;
      dp_level_reg <= 1'b0;
    end else begin
      dp_sync_reg <= {dp_sync_reg[1:0], drive_pulse_i};
      if (dp_sync_reg[1] == dp_sync_reg[2]) begin
        dp_level_reg <= dp_sync_reg[2];
      end
    end
  end

  // motion pin: same three-stage filter
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      mv_sync_reg  <= 3'h0;
      mv_level_reg <= 1'b0;
    end else begin
      mv_sync_reg <= {mv_sync_reg[1:0], axis_moving_i};
      if (mv_sync_reg[1] == mv_sync_reg[2]) begin
        mv_level_reg <= mv_sync_reg[2];
      end
    end
  end

  assign dp_edge  = dp_sync_reg[1] & dp_sync_reg[2] & ~dp_level_reg;
  assign any_stop = pulse_train_stop_cmd_i | sw_stop | ~mv_level_reg;
  assign do_start = pulse_train_start_cmd_i | sw_start;
  assign start_sel = pulse_train_start_cmd_i ? start_set_sel_i : sw_sel;
  assign last_pulse = act_reg.count != 16'h0000 && done_reg == act_reg.count;
  assign start_ok    = state_reg == ST_IDLE && do_start && !any_stop;
  assign run_stop    = state_reg == ST_RUN && any_stop;
  assign run_edge    = state_reg == ST_RUN && !any_stop && dp_edge;
  assign begin_pulse = run_edge && phase_reg == 16'h0000 && !last_pulse;
  assign finish_run  = run_edge && phase_reg == 16'h0000 && last_pulse;
  assign wrap_phase  = run_edge && phase_reg != 16'h0000 &&
                       phase_reg == act_reg.period - 16'h0001;
  assign width_hit   = run_edge && phase_reg != 16'h0000 && phase_reg == act_reg.width;

  // run state: start, self end after the last pulse, any stop
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (start_ok) begin
            state_reg <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (run_stop) begin
            state_reg <= ST_IDLE;
          end else if (finish_run) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // active set, latched at start
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      act_reg <= '0;
    end else if (start_ok) begin
      act_reg <= set_reg[start_sel];
    end
  end

  // position inside the period, in raw drive pulses
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      phase_reg <= 16'h0000;
    end else if (start_ok || run_stop) begin
      phase_reg <= 16'h0000;
    end else if (begin_pulse) begin
      phase_reg <= 16'h0001;
    end else if (wrap_phase) begin
      phase_reg <= 16'h0000;
    end else if (run_edge && phase_reg != 16'h0000) begin
      phase_reg <= phase_reg + 16'h0001;
    end
  end

  // pulses emitted in this run
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      done_reg <= 16'h0000;
    end else if (start_ok || run_stop) begin
      done_reg <= 16'h0000;
    end else if (begin_pulse) begin
      done_reg <= done_reg + 16'h0001;
    end
  end

  // split pulse output
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      out_reg <= 1'b0;
    end else if (run_stop || finish_run) begin
      out_reg <= 1'b0;
    end else if (begin_pulse) begin
      out_reg <= 1'b1;
    end else if (width_hit) begin
      out_reg <= 1'b0;
    end
  end

  assign split_pulse_o = out_reg;
  assign busy_o        = state_reg == ST_RUN;

  // checks
  a_stop_clears: assert property (@(posedge mclk_i) disable iff (reset_i)
    (state_reg == ST_RUN && any_stop) |=> (!split_pulse_o && !busy_o))
    else $error("stop did not clear output");
  a_rise_on_edge: assert property (@(posedge mclk_i) disable iff (reset_i)
    $rose(split_pulse_o) |-> $past(dp_edge))
    else $error("output rose without drive edge");
  a_count_bound: assert property (@(posedge mclk_i) disable iff (reset_i)
    (busy_o && act_reg.count != 16'h0000) |-> done_reg <= act_reg.count)
    else $error("too many pulses");
  a_width_end: assert property (@(posedge mclk_i) disable iff (reset_i)
    (busy_o && dp_edge && !any_stop && phase_reg == act_reg.width && phase_reg != 0)
      |=> !split_pulse_o)
    else $error("pulse exceeded width");
  a_period_wrap: assert property (@(posedge mclk_i) disable iff (reset_i)
    (busy_o && dp_edge && !any_stop && phase_reg == act_reg.period - 16'h0001)
      |=> phase_reg == 16'h0000)
    else $error("period wrap wrong");
  a_infinite_run: assert property (@(posedge mclk_i) disable iff (reset_i)
    (busy_o && act_reg.count == 16'h0000 && !any_stop) |=> busy_o)
    else $error("infinite run ended");
  a_start_loads: assert property (@(posedge mclk_i) disable iff (reset_i)
    (!busy_o && pulse_train_start_cmd_i && !any_stop)
      |=> (busy_o && act_reg == set_reg[$past(start_set_sel_i)]))
    else $error("start set not loaded");
  a_idle_low: assert property (@(posedge mclk_i) disable iff (reset_i)
    !busy_o |-> !split_pulse_o)
    else $error("output high while idle");
  a_edge_single: assert property (@(posedge mclk_i) disable iff (reset_i)
    dp_edge |=> !dp_edge)
    else $error("drive edge seen twice");
  a_start_low: assert property (@(posedge mclk_i) disable iff (reset_i)
    start_ok |=> (busy_o && !split_pulse_o && phase_reg == 16'h0000))
    else $error("run did not start clean");
  a_phase_step: assert property (@(posedge mclk_i) disable iff (reset_i)
    (run_edge && phase_reg != 16'h0000 && phase_reg != act_reg.period - 16'h0001)
      |=> phase_reg == 16'($past(phase_reg) + 16'h0001))
    else $error("phase did not advance by one");
  a_stop_wins: assert property (@(posedge mclk_i) disable iff (reset_i)
    (!busy_o && do_start && any_stop) |=> !busy_o)
    else $error("start beat stop");
  a_self_end: assert property (@(posedge mclk_i) disable iff (reset_i)
    finish_run |=> (!busy_o && done_reg == act_reg.count))
    else $error("run end count wrong");
  a_wait_once: assert property (@(posedge mclk_i) disable iff (reset_i)
    ((avs_read_i || avs_write_i) && avs_waitrequest_o) |=> !avs_waitrequest_o)
    else $error("more than one wait cycle");

  // main scenarios
  c_run_start: cover property (@(posedge mclk_i) disable iff (reset_i) $rose(busy_o));
  c_pulse_out: cover property (@(posedge mclk_i) disable iff (reset_i) $fell(split_pulse_o));
  c_self_end:  cover property (@(posedge mclk_i) disable iff (reset_i)
    $fell(busy_o) && !$past(any_stop));
  c_width_end: cover property (@(posedge mclk_i) disable iff (reset_i)
    width_hit);
  c_motion_stop: cover property (@(posedge mclk_i) disable iff (reset_i)
    (busy_o && !mv_level_reg) ##1 !busy_o);
endmodule

// [verification/drive_pulse_model.sv]
// axis side: drive pulses and motion level; the pulse line idles low between runs
module drive_pulse_model (
  input  wire logic mclk_i,
  input  wire logic run_i,
  input  wire logic slow_i,
  output logic      drive_pulse_o,
  output logic      moving_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [3:0] cnt_reg;
  // 4 or 8 clocks high and low, well above the edge detector's need
  always_ff @(posedge mclk_i) begin
    cnt_reg       <= run_i ? cnt_reg + 4'h1 : 4'h0;
    drive_pulse_o <= run_i & (slow_i ? cnt_reg[3] : cnt_reg[2]);
    moving_o      <= run_i;
  end
endmodule

// [verification/split_pulse_generator_test.sv]
module split_pulse_generator_test;
  timeunit 1ns;
  timeprecision 1ns;
  import split_pulse_pkg::*;
  logic        mclk_i, reset_i, rd_req, wr_req, run, slow, start_cmd, stop_cmd;
  logic        waitreq, drive_pulse, moving, split_pulse, busy, have_rise, prev_d, prev_o;
  logic [7:0]  address;
  logic [1:0]  set_sel;
  logic [31:0] wdata, rdata, rd;
  logic [15:0] lfsr, edg, rise_at, pulses, exp_p;
  logic [15:0] exp_q[$];
  logic [15:0] prst[4] = '{PERIOD_RST_0, PERIOD_RST_1, PERIOD_RST_2, PERIOD_RST_3};
  logic [15:0] wrst[4] = '{WIDTH_RST_0, WIDTH_RST_1, WIDTH_RST_2, WIDTH_RST_3};
  int          errors, num_checks;

  split_pulse_generator split_pulse_generator_inst (.mclk_i(mclk_i), .reset_i(reset_i),
    .avs_address_i(address), .avs_read_i(rd_req), .avs_write_i(wr_req),
    .avs_writedata_i(wdata), .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq),
    .drive_pulse_i(drive_pulse), .axis_moving_i(moving), .pulse_train_start_cmd_i(start_cmd),
    .pulse_train_stop_cmd_i(stop_cmd), .start_set_sel_i(set_sel), .split_pulse_o(split_pulse),
    .busy_o(busy));
  drive_pulse_model drive_pulse_model_inst (.mclk_i(mclk_i), .run_i(run), .slow_i(slow),
    .drive_pulse_o(drive_pulse), .moving_o(moving));

  initial begin
    mclk_i = 1'b0;
    forever #10 mclk_i = ~mclk_i;
  end

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task stop_test;
    if (errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  function logic [15:0] nxt(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function logic [7:0] sa(input int s);
    return OFS_SET_BASE + 8'(s << SET_STRIDE_SH);
  endfunction
  // one avalon transfer; request held until waitrequest is seen low at an edge
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int   n;
    logic w;
    n = 0;
    address <= a;
    wdata   <= d;
    wr_req  <= wr;
    rd_req  <= !wr;
    do begin
      @(posedge mclk_i);
      n++;
      w  = waitreq;
      rd = rdata;
    end while (w !== 1'b0 && n < 20);
    if (w !== 1'b0) begin
      errors++;
      stop_test();
    end
    wr_req <= 1'b0;
    rd_req <= 1'b0;
    @(posedge mclk_i);
  endtask

  // result watcher: measures each output pulse in drive pulses
  always @(posedge mclk_i) begin
    prev_d <= drive_pulse;
    prev_o <= split_pulse;
    if (drive_pulse && !prev_d) edg <= edg + 16'h1;
    if (split_pulse && !prev_o) begin
      if (have_rise) check("period", 32'(edg - rise_at), 32'(exp_p));
      rise_at   <= edg;
      have_rise <= 1'b1;
      pulses    <= pulses + 16'h1;
    end
    if (!split_pulse && prev_o) begin
      if (exp_q.size() == 0) check("extra pulse", 32'h1, 32'h0);
      else check("width", 32'(edg - rise_at), 32'(exp_q.pop_front()));
    end
  end

  // how: 0 start and stop on pins, 1 through the control register, 2 pin start, motion stop
  task run_set(input int s, input logic [15:0] cnt, input int how);
    logic [15:0] p, w, num;
    int          n;
    lfsr = nxt(lfsr);
    p    = 16'h2 + lfsr % 16'h5;
    lfsr = nxt(lfsr);
    w    = 16'h1 + lfsr % (p - 16'h1);
    num  = (cnt == 16'h0) ? 16'h3 : cnt;
    bus(1'b1, sa(s) + OFS_PERIOD, {16'h0, p});
    bus(1'b1, sa(s) + OFS_WIDTH, {16'h0, w});
    bus(1'b1, sa(s) + OFS_COUNT, {16'h0, cnt});
    exp_p     = p;
    pulses    = 16'h0;
    have_rise = 1'b0;
    for (n = 0; n < int'(num); n++) exp_q.push_back(w);
    run  <= 1'b1;
    slow <= s[0];
    repeat (8) @(posedge mclk_i);
    if (how == 1) bus(1'b1, OFS_CTRL, {26'h0, 2'(s), 4'h1});
    else begin
      start_cmd <= 1'b1;
      set_sel   <= 2'(s);
      @(posedge mclk_i);
      start_cmd <= 1'b0;
    end
    n = 0;
    while (exp_q.size() != 0 && n < 3000) begin
      @(posedge mclk_i);
      n++;
    end
    if (cnt == 16'h0) begin
      if (how == 2) run <= 1'b0;
      else if (how == 1) bus(1'b1, OFS_CTRL, 32'h2);
      else begin
        stop_cmd <= 1'b1;
        @(posedge mclk_i);
        stop_cmd <= 1'b0;
      end
      repeat (how == 2 ? 8 : 1) @(posedge mclk_i);
    end
    while (busy !== 1'b0 && n < 3000) begin
      @(posedge mclk_i);
      n++;
    end
    @(negedge mclk_i);
    check("busy", {31'h0, busy}, 32'h0);
    check("output", {31'h0, split_pulse}, 32'h0);
    check("pulses", {16'h0, pulses}, {16'h0, num});
    if (n >= 3000) begin
      errors++;
      stop_test();
    end
    @(posedge mclk_i);
    run <= 1'b0;
    if (cnt != 16'h0) bus(1'b0, OFS_STATUS, 32'h0);
    if (cnt != 16'h0) check("status count", {16'h0, rd[31:16]}, {16'h0, cnt});
    if (cnt != 16'h0) check("status flags", {30'h0, rd[1:0]}, 32'h0);
  endtask

  initial begin
    errors = 0; num_checks = 0; lfsr = 16'h6c01; reset_i = 1'b1;
    rd_req = 1'b0; wr_req = 1'b0; address = 8'h00; wdata = 32'h0; run = 1'b0; slow = 1'b0;
    start_cmd = 1'b0; stop_cmd = 1'b0; set_sel = 2'h0; edg = 16'h0; prev_d = 1'b0;
    prev_o = 1'b0; have_rise = 1'b0; pulses = 16'h0; rise_at = 16'h0; exp_p = 16'h0;
    repeat (12) @(posedge mclk_i);
    reset_i <= 1'b0;
    @(posedge mclk_i);
    for (int i = 0; i < 4; i++) begin
      bus(1'b0, sa(i) + OFS_PERIOD, 32'h0);
      check("period reset", rd, {16'h0, prst[i]});
      bus(1'b0, sa(i) + OFS_WIDTH, 32'h0);
      check("width reset", rd, {16'h0, wrst[i]});
    end
    bus(1'b0, 8'hf0, 32'h0);
    check("unmapped", rd, 32'h0);
    run <= 1'b1;
    repeat (8) @(posedge mclk_i);
    bus(1'b1, OFS_CTRL, 32'h3);
    @(negedge mclk_i);
    check("start with stop", {31'h0, busy}, 32'h0);
    @(posedge mclk_i);
    run <= 1'b0;
    run_set(0, 16'h2, 0);
    run_set(1, 16'h0, 2);
    run_set(2, 16'h0, 1);
    run_set(0, 16'h0, 0);
    run_set(3, 16'h3, 1);
    stop_test();
  end
endmodule
